//--- rtl/arct_timer_regs.svh
`ifndef ARCT_TIMER_REGS_SVH
`define ARCT_TIMER_REGS_SVH

`define ARCT_CTRL_ADDR 8'hC8
`define ARCT_RLL_ADDR 8'hCA
`define ARCT_RLH_ADDR 8'hCB
`define ARCT_CNTL_ADDR 8'hCC
`define ARCT_CNTH_ADDR 8'hCD

`define ARCT_BIT_HI_FLAG 7
`define ARCT_BIT_LO_FLAG 6
`define ARCT_BIT_LO_IEN 5
`define ARCT_BIT_CAP_EN 4
`define ARCT_BIT_SPLIT 3
`define ARCT_BIT_RUN 2
`define ARCT_BIT_CSS 1
`define ARCT_BIT_XCLK 0

`define ARCT_RESET_BYTE 8'h00
`define ARCT_BYTE_MAX 8'hFF
`define ARCT_SYS_DIV 12
`define ARCT_EXT_DIV 8

`endif

//--- rtl/arct_pkg.sv
package arct_pkg;
  typedef logic [7:0] arct_byte_t;
  typedef enum logic
  {
    ARCT_MODE_16 = 1'b0,
    ARCT_MODE_SPLIT = 1'b1
  } arct_mode_t;
  typedef enum logic
  {
    ARCT_CAP_SOF = 1'b0,
    ARCT_CAP_SLOW = 1'b1
  } arct_cap_src_t;
endpackage

//--- rtl/arct_timer.sv
`include "arct_timer_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module arct_timer
  import arct_pkg::*;
#(
  parameter int unsigned SYS_DIV = `ARCT_SYS_DIV,
  parameter int unsigned EXT_DIV = `ARCT_EXT_DIV
)
(
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic timer_irq_enable_i,
  input wire logic sof_event_i,
  input wire logic slow_osc_i,
  input wire logic ext_osc_i,
  output logic irq_o
);

  if (SYS_DIV < 2 || SYS_DIV > 16 || EXT_DIV < 2 || EXT_DIV > 16)
  begin : g_bad_div
    $error("arct_timer: divider out of range 2..16");
  end

  localparam logic [3:0] SYS_LAST = 4'(SYS_DIV - 1);
  localparam logic [3:0] EXT_LAST = 4'(EXT_DIV - 1);

  arct_byte_t ctl;
  arct_byte_t rl_lo;
  arct_byte_t rl_hi;
  arct_byte_t cnt_lo;
  arct_byte_t cnt_hi;
  logic [3:0] sys_cnt;
  logic [3:0] ext_cnt;
  logic ext_s1, ext_s2, ext_s3;
  logic slow_s1, slow_s2, slow_s3;

  arct_byte_t next_ctl;
  arct_byte_t next_rl_lo;
  arct_byte_t next_rl_hi;
  arct_byte_t next_cnt_lo;
  arct_byte_t next_cnt_hi;
  arct_byte_t rd_mux;

  // Register decode
  wire wr_ctl = sfr_wr_i && sfr_addr_i == `ARCT_CTRL_ADDR;
  wire wr_rll = sfr_wr_i && sfr_addr_i == `ARCT_RLL_ADDR;
  wire wr_rlh = sfr_wr_i && sfr_addr_i == `ARCT_RLH_ADDR;
  wire wr_cntl = sfr_wr_i && sfr_addr_i == `ARCT_CNTL_ADDR;
  wire wr_cnth = sfr_wr_i && sfr_addr_i == `ARCT_CNTH_ADDR;

  wire run = ctl[`ARCT_BIT_RUN];
  wire cap_en = ctl[`ARCT_BIT_CAP_EN];
  wire lo_ien = ctl[`ARCT_BIT_LO_IEN];
  wire hi_flag = ctl[`ARCT_BIT_HI_FLAG];
  wire lo_flag = ctl[`ARCT_BIT_LO_FLAG];
  arct_mode_t mode;
  arct_cap_src_t cap_src_sel;
  assign mode = arct_mode_t'(ctl[`ARCT_BIT_SPLIT]);
  assign cap_src_sel = arct_cap_src_t'(ctl[`ARCT_BIT_CSS]);
  wire split = mode == ARCT_MODE_SPLIT;

  // Timebases; the external path counts resynchronised edges only
  wire sys_tick = sys_cnt == SYS_LAST;
  wire ext_rise = ext_s2 && !ext_s3;
  wire ext_tick = ext_rise && ext_cnt == EXT_LAST;
  wire tick = ctl[`ARCT_BIT_XCLK] ? ext_tick : sys_tick;

  // Capture source
  wire slow_fall = slow_s3 && !slow_s2;
  wire cap_raw = cap_src_sel == ARCT_CAP_SLOW ? slow_fall : sof_event_i;
  wire cap_evt = cap_en && cap_raw;

  // Counting; the low byte ignores run control while split
  wire lo_step = tick && (split || run);
  wire hi_step = tick && run && (split || cnt_lo == `ARCT_BYTE_MAX);
  wire lo_wrap = lo_step && cnt_lo == `ARCT_BYTE_MAX;
  wire hi_wrap = hi_step && cnt_hi == `ARCT_BYTE_MAX;
  wire lo_reload = lo_wrap && (split || hi_wrap);

  assign next_cnt_lo = wr_cntl ? sfr_wdata_i :
                       lo_reload ? rl_lo :
                       lo_step ? 8'(cnt_lo + 8'h01) : cnt_lo;
  assign next_cnt_hi = wr_cnth ? sfr_wdata_i :
                       hi_wrap ? rl_hi :
                       hi_step ? 8'(cnt_hi + 8'h01) : cnt_hi;

  // Capture beats a software write in the same cycle
  assign next_rl_lo = cap_evt ? cnt_lo : wr_rll ? sfr_wdata_i : rl_lo;
  assign next_rl_hi = cap_evt ? cnt_hi : wr_rlh ? sfr_wdata_i : rl_hi;

  // Flags: a hardware set wins over a software clear in the same cycle
  wire set_hi = hi_wrap || cap_evt;
  wire set_lo = lo_wrap;
  arct_byte_t ctl_base;
  assign ctl_base = wr_ctl ? sfr_wdata_i : ctl;
  always_comb
  begin
    next_ctl = ctl_base;
    next_ctl[`ARCT_BIT_HI_FLAG] = ctl_base[`ARCT_BIT_HI_FLAG] || set_hi;
    next_ctl[`ARCT_BIT_LO_FLAG] = ctl_base[`ARCT_BIT_LO_FLAG] || set_lo;
  end

  wire next_irq = timer_irq_enable_i && (hi_flag || (lo_ien && lo_flag));

  always_comb
  begin
    if (sfr_addr_i == `ARCT_CTRL_ADDR)
      rd_mux = ctl;
    else if (sfr_addr_i == `ARCT_RLL_ADDR)
      rd_mux = rl_lo;
    else if (sfr_addr_i == `ARCT_RLH_ADDR)
      rd_mux = rl_hi;
    else if (sfr_addr_i == `ARCT_CNTL_ADDR)
      rd_mux = cnt_lo;
    else if (sfr_addr_i == `ARCT_CNTH_ADDR)
      rd_mux = cnt_hi;
    else
      rd_mux = `ARCT_RESET_BYTE;
  end

  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_s3 <= 1'b0;
      slow_s1 <= 1'b0;
      slow_s2 <= 1'b0;
      slow_s3 <= 1'b0;
    end
    else
    begin
      ext_s1 <= ext_osc_i;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
      slow_s1 <= slow_osc_i;
      slow_s2 <= slow_s1;
      slow_s3 <= slow_s2;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sys_cnt <= 4'h0;
      ext_cnt <= 4'h0;
    end
    else
    begin
      sys_cnt <= sys_tick ? 4'h0 : 4'(sys_cnt + 4'h1);
      if (ext_rise)
        ext_cnt <= ext_tick ? 4'h0 : 4'(ext_cnt + 4'h1);
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ctl <= `ARCT_RESET_BYTE;
      rl_lo <= `ARCT_RESET_BYTE;
      rl_hi <= `ARCT_RESET_BYTE;
      cnt_lo <= `ARCT_RESET_BYTE;
      cnt_hi <= `ARCT_RESET_BYTE;
    end
    else
    begin
      ctl <= next_ctl;
      rl_lo <= next_rl_lo;
      rl_hi <= next_rl_hi;
      cnt_lo <= next_cnt_lo;
      cnt_hi <= next_cnt_hi;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sfr_rdata_o <= `ARCT_RESET_BYTE;
      irq_o <= 1'b0;
    end
    else
    begin
      if (sfr_rd_i)
        sfr_rdata_o <= rd_mux;
      irq_o <= next_irq;
    end
  end

  // Checks
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  sequence low_wrap_s;
    lo_wrap && !wr_cntl;
  endsequence

  sequence full_wrap_s;
    !split && lo_wrap && hi_wrap && !wr_cntl && !wr_cnth;
  endsequence

  lo_flag_set_a: assert property (low_wrap_s |=> lo_flag)
    else $error("low flag not set after low byte wrap");

  lo_flag_hold_a: assert property (lo_flag && !wr_ctl |=> lo_flag)
    else $error("low flag cleared without a write");

  full_reload_a: assert property (full_wrap_s
    |=> cnt_lo == $past(rl_lo) && cnt_hi == $past(rl_hi) && hi_flag)
    else $error("16-bit wrap did not reload both bytes");

  split_lo_run_a: assert property (split && tick && !wr_cntl
    && cnt_lo != `ARCT_BYTE_MAX |=> cnt_lo == 8'($past(cnt_lo) + 8'h01))
    else $error("split low byte did not count");

  hold_stopped_a: assert property (!run && !split && !wr_cntl
    && !wr_cnth |=> $stable(cnt_lo) && $stable(cnt_hi))
    else $error("16-bit counter moved while stopped");

  capture_copy_a: assert property (cap_evt
    |=> rl_lo == $past(cnt_lo) && rl_hi == $past(cnt_hi) && hi_flag)
    else $error("capture did not copy the count");

  irq_follow_a: assert property ((timer_irq_enable_i && lo_ien
    && !wr_ctl) ##0 low_wrap_s ##1 timer_irq_enable_i |=> irq_o)
    else $error("no interrupt after low overflow");

  // Gap counter kept apart from the prescaler it watches
  logic [3:0] sys_gap;
  always_ff @(posedge core_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      sys_gap <= 4'h0;
    else
      sys_gap <= sys_tick ? 4'h0 : 4'(sys_gap + 4'h1);
  end

  sys_div_a: assert property (sys_tick |-> sys_gap == SYS_LAST)
    else $error("system prescale period is wrong");

  // Interrupt is registered, so it trails the capture by two edges
  sequence cap_seen_s;
    cap_evt && timer_irq_enable_i ##1 timer_irq_enable_i && !wr_ctl;
  endsequence

  cap_irq_a: assert property (cap_seen_s |=> irq_o)
    else $error("no interrupt after capture");

  hi_flag_hold_a: assert property (hi_flag && !wr_ctl
    |=> hi_flag)
    else $error("high flag cleared without a write");

  split_hi_stop_a: assert property (split && !run && !wr_cnth
    |=> $stable(cnt_hi))
    else $error("split high byte moved while stopped");

  split_lo_reload_a: assert property (split && lo_wrap
    && !wr_cntl |=> cnt_lo == $past(rl_lo))
    else $error("split low byte did not reload");

  split_hi_reload_a: assert property (split && hi_wrap
    && !wr_cnth |=> cnt_hi == $past(rl_hi) && hi_flag)
    else $error("split high byte did not reload");

  sof_ignored_a: assert property (cap_en
    && cap_src_sel == ARCT_CAP_SLOW && sof_event_i && !slow_fall
    && !wr_rll |=> $stable(rl_lo))
    else $error("frame event captured while slow source chosen");

  no_capture_a: assert property (!cap_en && !wr_rll
    |=> $stable(rl_lo))
    else $error("reload low changed without capture or write");

  rlh_write_a: assert property (wr_rlh && !cap_evt
    |=> rl_hi == $past(sfr_wdata_i))
    else $error("reload high write lost");

  rd_cnth_a: assert property (sfr_rd_i
    && sfr_addr_i == `ARCT_CNTH_ADDR |=> sfr_rdata_o == $past(cnt_hi))
    else $error("high count read wrong");

  hi16_step_a: assert property (!split && run && tick
    && cnt_lo == `ARCT_BYTE_MAX && cnt_hi != `ARCT_BYTE_MAX && !wr_cnth
    |=> cnt_hi == 8'($past(cnt_hi) + 8'h01))
    else $error("16-bit carry into high byte missing");

  lo_wrap16_a: assert property (!split && lo_wrap && !hi_wrap
    && !wr_cntl |=> cnt_lo == 8'h00 && lo_flag)
    else $error("16-bit low wrap wrong");

  irq_off_a: assert property (!timer_irq_enable_i |=> !irq_o)
    else $error("interrupt while timer interrupt disabled");

  irq_clear_a: assert property (!hi_flag && !lo_flag |=> !irq_o)
    else $error("interrupt with no flag set");

endmodule
`default_nettype wire

//--- verification/arct_timer_test.sv
`timescale 1ns/1ps
`default_nettype none
module arct_timer_test;
  import arct_pkg::*;
  logic clk = 0, rstn = 0, wr = 0, rd = 0, ien = 0;
  logic sof = 0, slow = 1, xo = 0, rd_d = 0, irq;
  logic [7:0] a = 8'h00, d = 8'h00, q;
  logic [15:0] exp_q[$];
  logic [15:0] e;
  int n_mismatch = 0, n_tests = 0, seed = 9439;
  arct_timer #(.SYS_DIV(2), .EXT_DIV(2)) u_dut (.core_clk_i(clk),
    .rstn_i(rstn), .sfr_addr_i(a), .sfr_wr_i(wr), .sfr_rd_i(rd),
    .sfr_wdata_i(d), .sfr_rdata_o(q), .timer_irq_enable_i(ien),
    .sof_event_i(sof), .slow_osc_i(slow), .ext_osc_i(xo), .irq_o(irq));
  initial forever #10 clk = ~clk;
  task automatic chk(input logic [7:0] g, input logic [7:0] m,
    input logic [7:0] x);
    n_tests++;
    if ((g & m) !== x)
    begin
      n_mismatch++;
      $display("FAIL t=%0t got %h exp %h", $time, g & m, x);
    end
  endtask
  // One bus request per edge, so a strobe is never assigned twice at once
  task automatic op(input logic r, input logic w, input logic [7:0] ad,
    input logic [7:0] dt);
    @(posedge clk);
    rd <= r;
    wr <= w;
    a <= ad;
    d <= dt;
  endtask
  task automatic put(input logic [7:0] ad, input logic [7:0] dt);
    op(1'b0, 1'b1, ad, dt);
  endtask
  task automatic get(input logic [7:0] ad, input logic [7:0] m,
    input logic [7:0] x);
    exp_q.push_back({m, x});
    op(1'b1, 1'b0, ad, 8'h00);
  endtask
  task automatic nop(input int n);
    repeat (n) op(1'b0, 1'b0, 8'h00, 8'h00);
  endtask
  task automatic pulse_sof();
    @(posedge clk);
    sof <= 1'b1;
    @(posedge clk);
    sof <= 1'b0;
  endtask
  always @(posedge clk) rd_d <= rd;
  always @(negedge clk)
    if (rd_d)
    begin
      e = exp_q.pop_front();
      chk(q, e[15:8], e[7:0]);
    end
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    end_of_test();
  end
  initial
  begin
    int v;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    ien <= 1'b1;
    for (int i = 8'hC8; i <= 8'hCD; i++) get(i[7:0], 8'hFF, 8'h00);
    repeat (4)
    begin
      v = $random(seed);
      put(8'hCA, v[7:0]);
      put(8'hCB, v[15:8]);
      put(8'hC9, v[23:16]);
      get(8'hCA, 8'hFF, v[7:0]);
      get(8'hCB, 8'hFF, v[15:8]);
      get(8'hC9, 8'hFF, 8'h00);
    end
    $display("test registers done");
    // A 40-cycle run holds 20 ticks whatever the prescaler phase
    put(8'hCC, 8'hF0);
    put(8'hCD, 8'h00);
    put(8'hC8, 8'h04);
    nop(35);
    get(8'hC8, 8'hFF, 8'h44);
    nop(3);
    put(8'hC8, 8'h00);
    nop(1);
    @(negedge clk);
    chk({7'h00, irq}, 8'h01, 8'h00);
    get(8'hCD, 8'hFF, 8'h01);
    get(8'hCC, 8'hFF, 8'h04);
    put(8'hCA, 8'hF0);
    put(8'hCB, 8'hFF);
    put(8'hCC, 8'hFE);
    put(8'hCD, 8'hFF);
    put(8'hC8, 8'h24);
    nop(8);
    get(8'hC8, 8'hFF, 8'hE4);
    put(8'hC8, 8'hE0);
    nop(3);
    @(negedge clk);
    chk({7'h00, irq}, 8'h01, 8'h01);
    get(8'hCD, 8'hFF, 8'hFF);
    get(8'hCC, 8'hF0, 8'hF0);
    put(8'hC8, 8'h00);
    nop(3);
    @(negedge clk);
    chk({7'h00, irq}, 8'h01, 8'h00);
    $display("test sixteen bit done");
    put(8'hCA, 8'hF0);
    put(8'hCC, 8'hFE);
    put(8'hCD, 8'h10);
    put(8'hC8, 8'h08);
    nop(10);
    get(8'hCD, 8'hFF, 8'h10);
    get(8'hC8, 8'hFF, 8'h48);
    get(8'hCC, 8'hF0, 8'hF0);
    put(8'hCB, 8'h80);
    put(8'hCD, 8'hFE);
    put(8'hC8, 8'h0C);
    nop(10);
    get(8'hCD, 8'hF8, 8'h80);
    get(8'hC8, 8'hBF, 8'h8C);
    put(8'hC8, 8'h00);
    $display("test split done");
    put(8'hCC, 8'h34);
    put(8'hCD, 8'h12);
    put(8'hC8, 8'h10);
    nop(1);
    pulse_sof();
    nop(3);
    get(8'hCB, 8'hFF, 8'h12);
    get(8'hCA, 8'hFF, 8'h34);
    get(8'hC8, 8'hFF, 8'h90);
    @(negedge clk);
    chk({7'h00, irq}, 8'h01, 8'h01);
    put(8'hC8, 8'h12);
    put(8'hCC, 8'h56);
    nop(1);
    pulse_sof();
    nop(4);
    get(8'hCA, 8'hFF, 8'h34);
    slow <= 1'b0;
    nop(8);
    get(8'hCA, 8'hFF, 8'h56);
    $display("test capture done");
    put(8'hC8, 8'h00);
    put(8'hCC, 8'h00);
    put(8'hC8, 8'h05);
    nop(1);
    repeat (16)
    begin
      @(posedge clk);
      xo <= ~xo;
      repeat (2) @(posedge clk);
    end
    nop(8);
    put(8'hC8, 8'h01);
    nop(2);
    get(8'hCC, 8'hFF, 8'h04);
    nop(3);
    $display("test external clock done");
    end_of_test();
  end
endmodule
`default_nettype wire
